// ===== include/spi_master_pkg.sv
package spi_master_pkg;
	localparam logic [11:0] OFF_TASK_START   = 12'h010;
	localparam logic [11:0] OFF_TASK_STOP    = 12'h014;
	localparam logic [11:0] OFF_EVENT_STATUS = 12'h100;
	localparam logic [11:0] OFF_INT_SET      = 12'h304;
	localparam logic [11:0] OFF_INT_DISABLE  = 12'h308;
	localparam logic [11:0] OFF_ENABLE       = 12'h500;
	localparam logic [11:0] OFF_CLK_PSEL     = 12'h508;
	localparam logic [11:0] OFF_OUT_PSEL     = 12'h50C;
	localparam logic [11:0] OFF_IN_PSEL      = 12'h510;
	localparam logic [11:0] OFF_BIT_RATE     = 12'h524;
	localparam logic [11:0] OFF_RX_PTR       = 12'h534;
	localparam logic [11:0] OFF_RX_MAX       = 12'h538;
	localparam logic [11:0] OFF_RX_AMOUNT    = 12'h53C;
	localparam logic [11:0] OFF_RX_LIST      = 12'h540;
	localparam logic [11:0] OFF_TX_PTR       = 12'h544;
	localparam logic [11:0] OFF_TX_MAX       = 12'h548;
	localparam logic [11:0] OFF_TX_AMOUNT    = 12'h54C;
	localparam logic [11:0] OFF_TX_LIST      = 12'h550;
	localparam logic [11:0] OFF_CONFIG       = 12'h554;
	localparam logic [11:0] OFF_ORC          = 12'h5C0;

	localparam int NUM_EVENTS  = 5;
	localparam int EV_STOPPED  = 0;
	localparam int EV_RX_DONE  = 1;
	localparam int EV_END      = 2;
	localparam int EV_TX_DONE  = 3;
	localparam int EV_STARTED  = 4;

	localparam logic [3:0] ENABLE_ON  = 4'h7;
	localparam logic [3:0] ENABLE_OFF = 4'h0;

	localparam int          PSEL_PIN_W       = 5;
	localparam int          PSEL_CONNECT_BIT = 31;
	localparam logic [31:0] PSEL_RESET       = 32'hFFFFFFFF;

	localparam int CFG_ORDER_BIT = 0;
	localparam int CFG_PHASE_BIT = 1;
	localparam int CFG_POL_BIT   = 2;

	localparam int         RATE_W     = 8;
	localparam logic [7:0] RATE_RESET = 8'h04;
	localparam logic [7:0] ORC_RESET  = 8'h00;
	localparam int         LIST_W     = 2;

	localparam int CLK_PERIOD_NS      = 40;
	localparam int START_DELAY_NS     = 1000;
	localparam int START_DELAY_CYCLES = START_DELAY_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE, ST_DELAY, ST_FETCH, ST_ASK, ST_LOAD, ST_SHIFT, ST_STORE, ST_DONE
	} state_type;
endpackage

// ===== rtl/spi_sync2.sv
`timescale 1ns/10ps
module spi_sync2 #(
	parameter int W = 32
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o  <= '0;
		end else if (ce_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// ===== rtl/spi_pin_router.sv
`timescale 1ns/10ps
module spi_pin_router (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        enable_i,
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	input  wire logic [31:0] sck_sel_i,
	input  wire logic [31:0] mosi_sel_i,
	output logic      [31:0] pin_out_o,
	output logic      [31:0] pin_oe_o
);
	logic sck_on;
	logic mosi_on;

	assign sck_on  = enable_i && !sck_sel_i[spi_master_pkg::PSEL_CONNECT_BIT];
	assign mosi_on = enable_i && !mosi_sel_i[spi_master_pkg::PSEL_CONNECT_BIT];

	// clock wins when both selects name the same pin
	for (genvar i = 0; i < 32; i++) begin : g_pin
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				pin_out_o[i] <= 1'b0;
				pin_oe_o[i]  <= 1'b0;
			end else if (ce_i) begin
				if (sck_on && sck_sel_i[spi_master_pkg::PSEL_PIN_W-1:0] == 5'(i)) begin
					pin_out_o[i] <= sck_i;
					pin_oe_o[i]  <= 1'b1;
				end else if (mosi_on && mosi_sel_i[spi_master_pkg::PSEL_PIN_W-1:0] == 5'(i)) begin
					pin_out_o[i] <= mosi_i;
					pin_oe_o[i]  <= 1'b1;
				end else begin
					pin_out_o[i] <= 1'b0;
					pin_oe_o[i]  <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== rtl/spi_master_regs.sv
`timescale 1ns/10ps
module spi_master_regs #(
	parameter int CNT_W = 13
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	input  wire logic [11:0] ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	output logic             IRQ_O,
	output logic      [31:0] MEM_ADDR_O,
	output logic             MEM_RD_O,
	input  wire logic [7:0]  MEM_RDATA_I,
	output logic             MEM_WR_O,
	output logic      [7:0]  MEM_WDATA_O,
	input  wire logic [31:0] PIN_IN_I,
	output logic      [31:0] PIN_OUT_O,
	output logic      [31:0] PIN_OE_O
);
	localparam int NE = spi_master_pkg::NUM_EVENTS;

	logic [NE-1:0]                    int_en;
	logic [NE-1:0]                    status;
	logic [NE-1:0]                    ev_hit;
	logic [3:0]                       enable;
	logic [31:0]                      sck_sel;
	logic [31:0]                      mosi_sel;
	logic [31:0]                      miso_sel;
	logic [spi_master_pkg::RATE_W-1:0] bit_rate;
	logic [31:0]                      rx_ptr;
	logic [31:0]                      tx_ptr;
	logic [CNT_W-1:0]                 rx_max;
	logic [CNT_W-1:0]                 tx_max;
	logic [CNT_W-1:0]                 rx_amount;
	logic [CNT_W-1:0]                 tx_amount;
	logic [spi_master_pkg::LIST_W-1:0] rx_list;
	logic [spi_master_pkg::LIST_W-1:0] tx_list;
	logic [2:0]                       config_bits;
	logic [7:0]                       over_read_character;

	spi_master_pkg::state_type        state;
	logic [7:0]                       delay_cnt;
	logic [spi_master_pkg::RATE_W-1:0] rate_cnt;
	logic [3:0]                       edge_cnt;
	logic [CNT_W-1:0]                 byte_idx;
	logic [CNT_W-1:0]                 tx_count;
	logic [CNT_W-1:0]                 rx_count;
	logic [7:0]                       tx_sr;
	logic [7:0]                       rx_sr;
	logic                             sck;
	logic                             mosi;
	logic [31:0]                      pin_sync;

	logic             enabled;
	logic             lsb_first;
	logic             phase;
	logic             polarity;
	logic             miso;
	logic [CNT_W-1:0] total;
	logic             start_go;
	logic             stop_go;
	logic             tick;
	logic             leading;
	logic             sample_ev;
	logic             drive_ev;
	logic [7:0]       load_data;
	logic             load_now;

	assign enabled   = (enable == spi_master_pkg::ENABLE_ON);
	assign lsb_first = config_bits[spi_master_pkg::CFG_ORDER_BIT];
	assign phase     = config_bits[spi_master_pkg::CFG_PHASE_BIT];
	assign polarity  = config_bits[spi_master_pkg::CFG_POL_BIT];
	assign total     = (tx_max > rx_max) ? tx_max : rx_max;
	assign start_go  = WR_I && ADDR_I == spi_master_pkg::OFF_TASK_START && WDATA_I[0] && enabled
		&& state == spi_master_pkg::ST_IDLE;
	assign stop_go   = WR_I && ADDR_I == spi_master_pkg::OFF_TASK_STOP && WDATA_I[0]
		&& state != spi_master_pkg::ST_IDLE;
	assign tick      = (rate_cnt == bit_rate);
	assign leading   = !edge_cnt[0];
	assign sample_ev = tick && (phase ? !leading : leading);
	assign drive_ev  = tick && (phase ? leading : (!leading && edge_cnt != 4'hF));
	// over-read character replaces buffer data past the transmit count
	assign load_data = (state == spi_master_pkg::ST_LOAD) ? MEM_RDATA_I : over_read_character;
	assign load_now  = state == spi_master_pkg::ST_LOAD
		|| (state == spi_master_pkg::ST_FETCH && byte_idx < total && byte_idx >= tx_max);

	// pins come from another domain: two flops before the selector looks
	spi_sync2 #(
		.W(32)
	) u_pin_sync (
		.clk_i  (CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i   (CE_I),
		.d_i    (PIN_IN_I),
		.q_o    (pin_sync)
	);

	// disconnected input reads as zero
	assign miso = !miso_sel[spi_master_pkg::PSEL_CONNECT_BIT]
		&& pin_sync[miso_sel[spi_master_pkg::PSEL_PIN_W-1:0]];

	spi_pin_router u_router (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.ce_i      (CE_I),
		.enable_i  (enabled),
		.sck_i     (sck),
		.mosi_i    (mosi),
		.sck_sel_i (sck_sel),
		.mosi_sel_i(mosi_sel),
		.pin_out_o (PIN_OUT_O),
		.pin_oe_o  (PIN_OE_O)
	);

	// software-written configuration
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			enable      <= spi_master_pkg::ENABLE_OFF;
			sck_sel     <= spi_master_pkg::PSEL_RESET;
			mosi_sel    <= spi_master_pkg::PSEL_RESET;
			miso_sel    <= spi_master_pkg::PSEL_RESET;
			bit_rate    <= spi_master_pkg::RATE_RESET;
			rx_ptr      <= '0;
			tx_ptr      <= '0;
			rx_max      <= '0;
			tx_max      <= '0;
			rx_list     <= '0;
			tx_list     <= '0;
			config_bits <= '0;
			over_read_character         <= spi_master_pkg::ORC_RESET;
		end else if (CE_I && WR_I) begin
			if (ADDR_I == spi_master_pkg::OFF_ENABLE) begin
				enable <= WDATA_I[3:0];
			end else if (ADDR_I == spi_master_pkg::OFF_CLK_PSEL) begin
				sck_sel <= WDATA_I;
			end else if (ADDR_I == spi_master_pkg::OFF_OUT_PSEL) begin
				mosi_sel <= WDATA_I;
			end else if (ADDR_I == spi_master_pkg::OFF_IN_PSEL) begin
				miso_sel <= WDATA_I;
			end else if (ADDR_I == spi_master_pkg::OFF_BIT_RATE) begin
				bit_rate <= WDATA_I[spi_master_pkg::RATE_W-1:0];
			end else if (ADDR_I == spi_master_pkg::OFF_RX_PTR) begin
				rx_ptr <= WDATA_I;
			end else if (ADDR_I == spi_master_pkg::OFF_RX_MAX) begin
				rx_max <= WDATA_I[CNT_W-1:0];
			end else if (ADDR_I == spi_master_pkg::OFF_RX_LIST) begin
				rx_list <= WDATA_I[spi_master_pkg::LIST_W-1:0];
			end else if (ADDR_I == spi_master_pkg::OFF_TX_PTR) begin
				tx_ptr <= WDATA_I;
			end else if (ADDR_I == spi_master_pkg::OFF_TX_MAX) begin
				tx_max <= WDATA_I[CNT_W-1:0];
			end else if (ADDR_I == spi_master_pkg::OFF_TX_LIST) begin
				tx_list <= WDATA_I[spi_master_pkg::LIST_W-1:0];
			end else if (ADDR_I == spi_master_pkg::OFF_CONFIG) begin
				config_bits <= WDATA_I[2:0];
			end else if (ADDR_I == spi_master_pkg::OFF_ORC) begin
				over_read_character <= WDATA_I[7:0];
			end
		end
	end

	// interrupt enables: set and disable live at different addresses
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			int_en <= '0;
		end else if (CE_I && WR_I) begin
			if (ADDR_I == spi_master_pkg::OFF_INT_SET) begin
				int_en <= int_en | WDATA_I[NE-1:0];
			end else if (ADDR_I == spi_master_pkg::OFF_INT_DISABLE) begin
				int_en <= int_en & ~WDATA_I[NE-1:0];
			end
		end
	end

	// sticky flags, cleared by a read; a same-cycle event survives the clear
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			status <= '0;
			IRQ_O  <= 1'b0;
		end else if (CE_I) begin
			if (RD_I && ADDR_I == spi_master_pkg::OFF_EVENT_STATUS) begin
				status <= ev_hit;
			end else begin
				status <= status | ev_hit;
			end
			IRQ_O <= |(status & int_en);
		end
	end

	// read port: data only in the cycle after the strobe
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= '0;
		end else if (CE_I) begin
			RDATA_O <= '0;
			if (RD_I) begin
				if (ADDR_I == spi_master_pkg::OFF_EVENT_STATUS) begin
					RDATA_O <= 32'(status);
				end else if (ADDR_I == spi_master_pkg::OFF_INT_SET || ADDR_I == spi_master_pkg::OFF_INT_DISABLE) begin
					RDATA_O <= 32'(int_en);
				end else if (ADDR_I == spi_master_pkg::OFF_ENABLE) begin
					RDATA_O <= 32'(enable);
				end else if (ADDR_I == spi_master_pkg::OFF_CLK_PSEL) begin
					RDATA_O <= sck_sel;
				end else if (ADDR_I == spi_master_pkg::OFF_OUT_PSEL) begin
					RDATA_O <= mosi_sel;
				end else if (ADDR_I == spi_master_pkg::OFF_IN_PSEL) begin
					RDATA_O <= miso_sel;
				end else if (ADDR_I == spi_master_pkg::OFF_BIT_RATE) begin
					RDATA_O <= 32'(bit_rate);
				end else if (ADDR_I == spi_master_pkg::OFF_RX_PTR) begin
					RDATA_O <= rx_ptr;
				end else if (ADDR_I == spi_master_pkg::OFF_RX_MAX) begin
					RDATA_O <= 32'(rx_max);
				end else if (ADDR_I == spi_master_pkg::OFF_RX_AMOUNT) begin
					RDATA_O <= 32'(rx_amount);
				end else if (ADDR_I == spi_master_pkg::OFF_RX_LIST) begin
					RDATA_O <= 32'(rx_list);
				end else if (ADDR_I == spi_master_pkg::OFF_TX_PTR) begin
					RDATA_O <= tx_ptr;
				end else if (ADDR_I == spi_master_pkg::OFF_TX_MAX) begin
					RDATA_O <= 32'(tx_max);
				end else if (ADDR_I == spi_master_pkg::OFF_TX_AMOUNT) begin
					RDATA_O <= 32'(tx_amount);
				end else if (ADDR_I == spi_master_pkg::OFF_TX_LIST) begin
					RDATA_O <= 32'(tx_list);
				end else if (ADDR_I == spi_master_pkg::OFF_CONFIG) begin
					RDATA_O <= 32'(config_bits);
				end else if (ADDR_I == spi_master_pkg::OFF_ORC) begin
					RDATA_O <= 32'(over_read_character);
				end
			end
		end
	end

	// transfer sequencer; the sampled input lags the pin by the synchroniser,
	// so a half period of at least four clocks is assumed
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state       <= spi_master_pkg::ST_IDLE;
			delay_cnt   <= '0;
			rate_cnt    <= '0;
			edge_cnt    <= '0;
			byte_idx    <= '0;
			tx_count    <= '0;
			rx_count    <= '0;
			tx_amount   <= '0;
			rx_amount   <= '0;
			tx_sr       <= '0;
			rx_sr       <= '0;
			sck         <= 1'b0;
			mosi        <= 1'b0;
			ev_hit      <= '0;
			MEM_ADDR_O  <= '0;
			MEM_RD_O    <= 1'b0;
			MEM_WR_O    <= 1'b0;
			MEM_WDATA_O <= '0;
		end else if (CE_I) begin
			ev_hit   <= '0;
			MEM_RD_O <= 1'b0;
			MEM_WR_O <= 1'b0;
			if (load_now) begin
				rate_cnt <= '0;
				edge_cnt <= '0;
				if (phase) begin
					tx_sr <= load_data;
				end else begin
					mosi  <= lsb_first ? load_data[0] : load_data[7];
					tx_sr <= lsb_first ? {1'b0, load_data[7:1]} : {load_data[6:0], 1'b0};
				end
			end
			if (!enabled || stop_go) begin
				state <= spi_master_pkg::ST_IDLE;
				sck   <= polarity;
				if (state != spi_master_pkg::ST_IDLE) begin
					tx_amount               <= tx_count;
					rx_amount               <= rx_count;
					ev_hit[spi_master_pkg::EV_STOPPED] <= 1'b1;
				end
			end else begin
				case (state)
					spi_master_pkg::ST_IDLE: begin
						sck <= polarity;
						if (start_go) begin
							state    <= spi_master_pkg::ST_DELAY;
							delay_cnt <= '0;
							byte_idx <= '0;
							tx_count <= '0;
							rx_count <= '0;
							ev_hit[spi_master_pkg::EV_STARTED] <= 1'b1;
						end
					end
					spi_master_pkg::ST_DELAY: begin
						delay_cnt <= delay_cnt + 8'h01;
						if (delay_cnt == 8'(spi_master_pkg::START_DELAY_CYCLES - 1)) begin
							state <= spi_master_pkg::ST_FETCH;
						end
					end
					spi_master_pkg::ST_FETCH: begin
						if (byte_idx >= total) begin
							state <= spi_master_pkg::ST_DONE;
						end else if (byte_idx < tx_max) begin
							MEM_RD_O   <= 1'b1;
							MEM_ADDR_O <= tx_ptr + 32'(byte_idx);
							state      <= spi_master_pkg::ST_ASK;
						end else begin
							state <= spi_master_pkg::ST_SHIFT;
						end
					end
					spi_master_pkg::ST_ASK: begin
						state <= spi_master_pkg::ST_LOAD;
					end
					spi_master_pkg::ST_LOAD: begin
						tx_count <= tx_count + 1'b1;
						state    <= spi_master_pkg::ST_SHIFT;
					end
					spi_master_pkg::ST_SHIFT: begin
						rate_cnt <= tick ? '0 : rate_cnt + 1'b1;
						if (tick) begin
							sck      <= ~sck;
							edge_cnt <= edge_cnt + 4'h1;
							if (edge_cnt == 4'hF) begin
								state <= spi_master_pkg::ST_STORE;
							end
						end
						if (sample_ev) begin
							rx_sr <= lsb_first ? {miso, rx_sr[7:1]} : {rx_sr[6:0], miso};
						end
						if (drive_ev) begin
							mosi  <= lsb_first ? tx_sr[0] : tx_sr[7];
							tx_sr <= lsb_first ? {1'b0, tx_sr[7:1]} : {tx_sr[6:0], 1'b0};
						end
					end
					spi_master_pkg::ST_STORE: begin
						if (byte_idx < rx_max) begin
							MEM_WR_O    <= 1'b1;
							MEM_ADDR_O  <= rx_ptr + 32'(byte_idx);
							MEM_WDATA_O <= rx_sr;
							rx_count    <= rx_count + 1'b1;
						end
						byte_idx <= byte_idx + 1'b1;
						state    <= spi_master_pkg::ST_FETCH;
					end
					spi_master_pkg::ST_DONE: begin
						tx_amount <= tx_count;
						rx_amount <= rx_count;
						ev_hit[spi_master_pkg::EV_END]     <= 1'b1;
						ev_hit[spi_master_pkg::EV_RX_DONE] <= 1'b1;
						ev_hit[spi_master_pkg::EV_TX_DONE] <= 1'b1;
						state <= spi_master_pkg::ST_IDLE;
					end
					default: begin
						state <= spi_master_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I || !CE_I);

	AST_INT_CLR: assert property ((WR_I && ADDR_I == spi_master_pkg::OFF_INT_DISABLE && WDATA_I[0])
		|=> !int_en[0]) else $error("disable write left enable set");
	AST_INT_SET: assert property ((WR_I && ADDR_I == spi_master_pkg::OFF_INT_SET && WDATA_I[1])
		|=> int_en[1] ##1 (RDATA_O[1] || !$past(RD_I) || $past(ADDR_I) != spi_master_pkg::OFF_INT_DISABLE))
		else $error("set write did not enable");
	AST_IRQ: assert property (|(status & int_en) |=> IRQ_O) else $error("irq not raised");
	AST_ENABLE: assert property (!enabled |=> state == spi_master_pkg::ST_IDLE)
		else $error("runs while disabled");
	AST_PIN_OFF: assert property ((sck_sel[31] && mosi_sel[31]) [*2] |=> PIN_OE_O == 32'h00000000)
		else $error("disconnected pin driven");
	AST_TX_LIMIT: assert property (MEM_RD_O |-> $past(byte_idx) < tx_max) else $error("fetch past max count");
	AST_RX_LIMIT: assert property (MEM_WR_O |-> $past(byte_idx) < rx_max) else $error("store past max count");
	AST_AMOUNT: assert property ($past(state == spi_master_pkg::ST_DONE)
		|-> tx_amount <= tx_max && rx_amount <= rx_max) else $error("amount above max count");
	AST_ORDER: assert property ((load_now && !phase)
		|=> mosi == ($past(lsb_first) ? $past(load_data[0]) : $past(load_data[7])))
		else $error("first bit in wrong order");
	AST_PHASE: assert property ((sample_ev && state == spi_master_pkg::ST_SHIFT) |=> sck == (polarity ^ ~phase))
		else $error("sample on wrong edge");
	AST_IDLE_POL: assert property ((state == spi_master_pkg::ST_IDLE && $past(state) == spi_master_pkg::ST_IDLE)
		|-> sck == $past(polarity)) else $error("idle clock level wrong");
	AST_ORC: assert property ((load_now && byte_idx >= tx_max) |-> load_data == over_read_character) else $error("orc not used");
	AST_START: assert property (start_go |=> (state == spi_master_pkg::ST_DELAY) [*8] ##18
		(state == spi_master_pkg::ST_FETCH || !enabled || $past(stop_go))) else $error("start delay wrong");
endmodule

// ===== verif/spi_slave_model.sv
`timescale 1ns/10ps
module spi_slave_model (
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	input  wire logic        clr_i,
	input  wire logic [2:0]  mode_i,
	input  wire logic [7:0]  tx_i,
	output logic             miso_o,
	output logic      [23:0] rx_o,
	output int               bits_o
);
	int   sh;
	int   j;
	logic last = 1'b0;

	// next bit index trails the shift edges; phase 1 has no bit ready before its first edge
	always_comb begin
		j = (sh + 8 - int'(mode_i[1])) % 8;
		miso_o = mode_i[0] ? tx_i[j] : tx_i[7 - j];
	end

	always @(sck_i, clr_i) begin
		if (clr_i) begin
			bits_o = 0;
			sh = 0;
			rx_o = 24'h000000;
			last = sck_i;
		end else if (sck_i !== last) begin
			last = sck_i;
			if ((sck_i != mode_i[2]) != mode_i[1]) begin
				rx_o = mode_i[0] ? {mosi_i, rx_o[23:1]} : {rx_o[22:0], mosi_i};
				bits_o++;
			end else begin
				sh++;
			end
		end
	end
endmodule

// ===== verif/spi_master_register_interface_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h exp %h", $time, g, e); end end
module spi_master_register_interface_tb;
	typedef struct packed {logic [11:0] wa; logic [31:0] d; logic [11:0] ra; logic [31:0] e;} row_type;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        clr = 1'b0;
	logic [2:0]  mode = 3'h0;
	logic [7:0]  mem_rdata = 8'h00;
	logic [31:0] rdata, mem_addr, pin_out, pin_oe, v;
	logic        irq, mem_rd, mem_wr, miso;
	logic [7:0]  mem_wdata, rx_mem [256];
	logic [23:0] srx;
	int          num_errors = 0, compares = 0, n, sbits, wcnt = 0;
	row_type     rows [16];

	always #20 clk = ~clk;
	// memory answers one cycle after the request, bytes derived from the address
	always @(posedge clk) if (mem_rd) mem_rdata <= mem_addr[7:0] + 8'h30;
	always @(posedge clk) if (mem_wr) rx_mem[mem_addr[7:0]] <= mem_wdata;
	always @(posedge clk) wcnt <= clr ? 0 : wcnt + int'(mem_wr);

	spi_master_regs dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd),
		.MEM_RDATA_I(mem_rdata), .MEM_WR_O(mem_wr), .MEM_WDATA_O(mem_wdata), .PIN_IN_I({22'h0, miso, 9'h0}),
		.PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe));

	spi_slave_model slave_u (.sck_i(pin_out[2]), .mosi_i(pin_out[5]), .clr_i(clr), .mode_i(mode),
		.tx_i(8'hA0 + {5'h00, mode}), .miso_o(miso), .rx_o(srx), .bits_o(sbits));

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		#2000000;
		num_errors++;
		stop_test();
	end

	initial begin
		rows = '{'{12'h304, 32'h1F, 12'h308, 32'h1F}, '{12'h308, 32'h1A, 12'h304, 32'h05},
			'{12'h308, 32'h0, 12'h308, 32'h05}, '{12'h548, 32'h1FFF, 12'h548, 32'h1FFF},
			'{12'h54C, 32'h5, 12'h54C, 32'h0}, '{12'h600, 32'h1, 12'h600, 32'h0},
			'{12'h508, 32'h2, 12'h508, 32'h2}, '{12'h50C, 32'h5, 12'h50C, 32'h5},
			'{12'h510, 32'h9, 12'h510, 32'h9}, '{12'h524, 32'h3, 12'h524, 32'h3},
			'{12'h534, 32'h100, 12'h534, 32'h100}, '{12'h544, 32'h40, 12'h544, 32'h40},
			'{12'h538, 32'h3, 12'h538, 32'h3}, '{12'h548, 32'h2, 12'h548, 32'h2},
			'{12'h5C0, 32'h5A, 12'h5C0, 32'h5A}, '{12'h500, 32'h7, 12'h500, 32'h7}};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr_reg(rows[i].wa, rows[i].d);
			rd_reg(rows[i].ra, v);
			`CHK(v, rows[i].e)
		end
		// every order, phase and polarity; three bytes with two from memory, the last over-read
		for (int m = 0; m < 8; m++) begin
			wr_reg(12'h554, 32'(m));
			@(posedge clk);
			mode <= 3'(m);
			clr <= 1'b1;
			// hold the clear until a new idle level has reached the pin
			repeat (2) @(posedge clk);
			clr <= 1'b0;
			wr_reg(12'h010, 32'h1);
			for (n = 0; pin_out[2] === mode[2] && n < 200; n++) @(posedge clk);
			`CHK(n > 20 && n < 45, 1'b1)
			for (n = 0; irq !== 1'b1 && n < 3000; n++) @(posedge clk);
			`CHK(irq, 1'b1)
			rd_reg(12'h100, v);
			`CHK(v, 32'h1E)
			@(posedge clk);
			#1;
			`CHK({irq, pin_oe[9], pin_oe[5], pin_oe[2], pin_out[2]}, {4'b0011, mode[2]})
			`CHK(sbits, 24)
			`CHK(srx, m[0] ? 24'h5A7170 : 24'h70715A)
			`CHK({rx_mem[0], rx_mem[2]}, {2{8'hA0 + 8'(m)}})
			`CHK(wcnt, 3)
			rd_reg(12'h53C, v);
			`CHK(v, 32'h3)
			rd_reg(12'h54C, v);
			`CHK(v, 32'h2)
		end
		// disable in mid transfer aborts it, then a start while disabled is ignored
		wr_reg(12'h010, 32'h1);
		repeat (60) @(posedge clk);
		wr_reg(12'h500, 32'h0);
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b1)
		// a read while frozen must not clear the flags
		ce <= 1'b0;
		rd_reg(12'h100, v);
		ce <= 1'b1;
		rd_reg(12'h100, v);
		`CHK(v, 32'h11)
		wr_reg(12'h010, 32'h1);
		repeat (40) @(posedge clk);
		rd_reg(12'h100, v);
		`CHK(v, 32'h0)
		// stop inside the first byte: one byte fetched, none stored
		wr_reg(12'h500, 32'h7);
		wr_reg(12'h010, 32'h1);
		repeat (60) @(posedge clk);
		wr_reg(12'h014, 32'h1);
		rd_reg(12'h54C, v);
		`CHK(v, 32'h1)
		rd_reg(12'h53C, v);
		`CHK(v, 32'h0)
		rd_reg(12'h100, v);
		`CHK(v, 32'h11)
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK(pin_oe, 32'h0)
		rd_reg(12'h508, v);
		`CHK(v, 32'hFFFFFFFF)
		rd_reg(12'h54C, v);
		`CHK(v, 32'h0)
		rd_reg(12'h53C, v);
		`CHK(v, 32'h0)
		rd_reg(12'h308, v);
		`CHK(v, 32'h0)
		rd_reg(12'h554, v);
		`CHK(v, 32'h0)
		stop_test();
	end
endmodule
